// ==== core/uhrh_cfg_regs.v ====
// Contract
// - low-speed start only if frame count exceeds limit
// - limit is 14-bit full-speed bit times
// - port count always reads three
// - power switch mode resets 0, writable
// - no power switch resets 1, writable
// - compound device flag reads 0, read-only
// - overcurrent mode resets 0, writable
// - no overcurrent protect resets 1, writable
// - power good delay 8 bits, 2 ms, stored
// - nonremovable bits 1..3, others reserved
// - per-port power mask bits 17..19, others reserved
// - frame count reloads from interval each frame
// - nonremovable port shows connected after hub reset
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uhrh_map.vh"

module uhrh_cfg_regs (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        bit_tick,
    input  wire [13:0] frame_interval_value,
    input  wire        root_hub_reset,
    input  wire [2:0]  port_connected_clr,
    output reg         frame_start,
    output reg  [13:0] frame_left_count,
    output reg         low_speed_ok,
    output reg  [2:0]  port_connected,
    output wire [13:0] low_speed_limit,
    output wire        power_switch_mode,
    output wire        no_power_switch,
    output wire        overcurrent_mode,
    output wire        no_overcurrent_protect,
    output wire [7:0]  power_good_delay,
    output wire [2:0]  nonremovable_mask,
    output wire [2:0]  per_port_power_mask
);

    // ------------------------------------------------------------
    // register select codes
    // ------------------------------------------------------------
    localparam [2:0] SEL_LSL  = 3'h0;
    localparam [2:0] SEL_A    = 3'h1;
    localparam [2:0] SEL_B    = 3'h2;
    localparam [2:0] SEL_STAT = 3'h3;
    localparam [2:0] SEL_NONE = 3'h7;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // 0: low-speed limit, 1: descriptor a, 2: descriptor b, 3: frame status
    function [2:0] addr_sel;
        input [31:0] addr;
        begin
            case (addr)
                `UHRH_LS_THRESH_ADDR:  addr_sel = SEL_LSL;
                `UHRH_DESC_A_ADDR:     addr_sel = SEL_A;
                `UHRH_DESC_B_ADDR:     addr_sel = SEL_B;
                `UHRH_FRAME_STAT_ADDR: addr_sel = SEL_STAT;
                default:               addr_sel = SEL_NONE;
            endcase
        end
    endfunction

    function [31:0] merge_lanes;
        input [31:0] old;
        input [31:0] wdat;
        input [3:0]  strb;
        integer      i;
        begin
            merge_lanes = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_lanes[i*8 +: 8] = wdat[i*8 +: 8];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------
    // stored fields
    // ------------------------------------------------------------
    reg [13:0] lsl_r;
    reg        psm_r;
    reg        nps_r;
    reg        ocm_r;
    reg        no_overcurrent_protect_r;
    reg [7:0]  pgd_r;
    reg [2:0]  nrm_r;
    reg [2:0]  ppm_r;

    assign low_speed_limit        = lsl_r;
    assign power_switch_mode      = psm_r;
    assign no_power_switch        = nps_r;
    assign overcurrent_mode       = ocm_r;
    assign no_overcurrent_protect = no_overcurrent_protect_r;
    assign power_good_delay       = pgd_r;
    assign nonremovable_mask      = nrm_r;
    assign per_port_power_mask    = ppm_r;

    // ------------------------------------------------------------
    // register images
    // ------------------------------------------------------------
    reg [31:0] img_lsl;
    reg [31:0] img_a;
    reg [31:0] img_b;
    reg [31:0] img_stat;

    always @* begin
        img_lsl                         = 32'h00000000;
        img_lsl[`UHRH_LSL_MSB:0]        = lsl_r;
        img_a                           = 32'h00000000;
        img_a[`UHRH_PORT_CNT_LSB +: 8]  = `UHRH_PORT_CNT;
        img_a[`UHRH_PSM_BIT]            = psm_r;
        img_a[`UHRH_NPS_BIT]            = nps_r;
        img_a[`UHRH_CDF_BIT]            = `UHRH_CDF_VAL;
        img_a[`UHRH_OCM_BIT]            = ocm_r;
        img_a[`UHRH_NO_OVERCURRENT_PROTECT_BIT]           = no_overcurrent_protect_r;
        img_a[`UHRH_PGD_LSB +: 8]       = pgd_r;
        img_b                           = 32'h00000000;
        img_b[`UHRH_NRM_LSB +: 3]       = nrm_r;
        img_b[`UHRH_PPM_LSB +: 3]       = ppm_r;
        img_stat                        = 32'h00000000;
        img_stat[13:0]                  = frame_left_count;
        img_stat[`UHRH_LSOK_BIT]        = low_speed_ok;
    end

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    reg        aw_held_r;
    reg [31:0] aw_addr_r;
    reg        w_held_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;

    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;

    // both halves held; readies stay low until bready
    wire [2:0]  wr_sel = addr_sel(aw_addr_r);
    wire        wr_go  = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire [31:0] new_lsl = merge_lanes(img_lsl, w_data_r, w_strb_r);
    wire [31:0] new_a   = merge_lanes(img_a, w_data_r, w_strb_r);
    wire [31:0] new_b   = merge_lanes(img_b, w_data_r, w_strb_r);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r    <= 1'b0;
            aw_addr_r    <= 32'h00000000;
            w_held_r     <= 1'b0;
            w_data_r     <= 32'h00000000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `UHRH_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == SEL_NONE) ? `UHRH_RESP_SLVERR : `UHRH_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            lsl_r  <= `UHRH_LSL_RST;
            psm_r  <= `UHRH_PSM_RST;
            nps_r  <= `UHRH_NPS_RST;
            ocm_r  <= `UHRH_OCM_RST;
            no_overcurrent_protect_r <= `UHRH_NO_OVERCURRENT_PROTECT_RST;
            pgd_r  <= `UHRH_PGD_RST;
            nrm_r  <= 3'h0;
            ppm_r  <= 3'h0;
        end else if (wr_go) begin
            case (wr_sel)
                SEL_LSL: begin
                    lsl_r <= new_lsl[`UHRH_LSL_MSB:0];
                end
                SEL_A: begin
                    psm_r  <= new_a[`UHRH_PSM_BIT];
                    nps_r  <= new_a[`UHRH_NPS_BIT];
                    ocm_r  <= new_a[`UHRH_OCM_BIT];
                    no_overcurrent_protect_r <= new_a[`UHRH_NO_OVERCURRENT_PROTECT_BIT];
                    pgd_r  <= new_a[`UHRH_PGD_LSB +: 8];
                end
                SEL_B: begin
                    nrm_r <= new_b[`UHRH_NRM_LSB +: 3];
                    ppm_r <= new_b[`UHRH_PPM_LSB +: 3];
                end
                default: begin
                    lsl_r <= lsl_r;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;

    reg [31:0] rd_mux;
    always @* begin
        case (addr_sel(s_axi_araddr))
            SEL_LSL:  rd_mux = img_lsl;
            SEL_A:    rd_mux = img_a;
            SEL_B:    rd_mux = img_b;
            SEL_STAT: rd_mux = img_stat;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `UHRH_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (addr_sel(s_axi_araddr) == SEL_NONE) ?
                            `UHRH_RESP_SLVERR : `UHRH_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // frame timing and low-speed gate
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            frame_left_count <= 14'h0000;
            frame_start      <= 1'b0;
            low_speed_ok     <= 1'b0;
        end else begin
            frame_start <= 1'b0;
            if (bit_tick) begin
                if (frame_left_count == 14'h0000) begin
                    frame_left_count <= frame_interval_value;
                    frame_start      <= 1'b1;
                end else begin
                    frame_left_count <= frame_left_count - 14'h0001;
                end
            end
            // gate lags the count by one cycle
            low_speed_ok <= (frame_left_count > lsl_r);
        end
    end

    // ------------------------------------------------------------
    // port connection after root hub reset
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            port_connected <= 3'h0;
        end else begin
            // set wins over clear in the same cycle
            port_connected <= (port_connected & ~port_connected_clr)
                            | ({3{root_hub_reset}} & nrm_r);
        end
    end

endmodule // uhrh_cfg_regs
`default_nettype wire

// ==== core/uhrh_map.vh ====
`ifndef UHRH_MAP_VH
`define UHRH_MAP_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define UHRH_LS_THRESH_ADDR   32'h4004C044
`define UHRH_DESC_A_ADDR      32'h4004C048
`define UHRH_DESC_B_ADDR      32'h4004C04C
`define UHRH_FRAME_STAT_ADDR  32'h4004C0FC

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UHRH_LSL_MSB          13
`define UHRH_PORT_CNT_LSB     0
`define UHRH_PSM_BIT          8
`define UHRH_NPS_BIT          9
`define UHRH_CDF_BIT          10
`define UHRH_OCM_BIT          11
`define UHRH_NO_OVERCURRENT_PROTECT_BIT         12
`define UHRH_PGD_LSB          24
`define UHRH_NRM_LSB          1
`define UHRH_PPM_LSB          17
`define UHRH_LSOK_BIT         31

// ----------------------------------------------------------------
// reset and fixed values
// ----------------------------------------------------------------
`define UHRH_PORT_CNT         8'h03
`define UHRH_PSM_RST          1'b0
`define UHRH_NPS_RST          1'b1
`define UHRH_CDF_VAL          1'b0
`define UHRH_OCM_RST          1'b0
`define UHRH_NO_OVERCURRENT_PROTECT_RST         1'b1
`define UHRH_PGD_RST          8'h00
`define UHRH_LSL_RST          14'h0000
`define UHRH_PGD_UNIT_MS      2

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define UHRH_RESP_OKAY        2'b00
`define UHRH_RESP_SLVERR      2'b10

`endif

// ==== testbench/uhrh_cfg_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module uhrh_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        bit_tick,
    input wire logic [13:0] frame_interval_value,
    input wire logic        root_hub_reset,
    input wire logic [2:0]  port_connected_clr,
    input wire logic        frame_start,
    input wire logic [13:0] frame_left_count,
    input wire logic        low_speed_ok,
    input wire logic [2:0]  port_connected,
    input wire logic [13:0] low_speed_limit,
    input wire logic [2:0]  nonremovable_mask
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // frame count steps
    // ----------------------------------------------------------------
    sequence s_wrap;
        bit_tick && frame_left_count == 14'h0000;
    endsequence
    sequence s_step;
        bit_tick && frame_left_count != 14'h0000;
    endsequence
    chk_frame_reload: assert property (s_wrap |=> frame_left_count == $past(frame_interval_value))
        else $error("frame count not reloaded");
    chk_count_step: assert property (s_step |=> frame_left_count == $past(frame_left_count) - 14'h0001)
        else $error("frame count not decremented");
    chk_count_hold: assert property (!bit_tick |=> $stable(frame_left_count))
        else $error("frame count moved without tick");
    chk_start_cause: assert property (frame_start |-> $past(bit_tick) && $past(frame_left_count) == 14'h0000)
        else $error("frame start without reload");
    chk_ls_follow: assert property (1'h1 |=> low_speed_ok == ($past(frame_left_count) > $past(low_speed_limit)))
        else $error("low speed ok wrong");
    // ----------------------------------------------------------------
    // port connection flags
    // ----------------------------------------------------------------
    chk_conn_set: assert property (root_hub_reset |=> (port_connected & $past(nonremovable_mask)) == $past(nonremovable_mask))
        else $error("fixed port not connected");
    chk_conn_clr: assert property (port_connected_clr != 3'h0 && !root_hub_reset |=> (port_connected & $past(port_connected_clr)) == 3'h0)
        else $error("connect flag not cleared");
    chk_conn_hold: assert property (!root_hub_reset && port_connected_clr == 3'h0 |=> $stable(port_connected))
        else $error("connect flag moved");
endmodule // uhrh_chk
bind uhrh_cfg_regs uhrh_chk u_chk (.aclk, .aresetn, .bit_tick, .frame_interval_value, .root_hub_reset,
    .port_connected_clr, .frame_start, .frame_left_count, .low_speed_ok, .port_connected,
    .low_speed_limit, .nonremovable_mask);
`default_nettype wire

// ==== testbench/uhrh_port_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module uhrh_port_model #(parameter int TICK_DIV = 4) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        tick_en,
    input wire logic [2:0]  clr_req,
    output var logic        bit_tick,
    output var logic [2:0]  port_connected_clr
);
    logic [3:0] div_r;
    // bit clock stands still while tick_en is low or in reset
    always @(posedge aclk) begin
        if (!aresetn || !tick_en) begin
            div_r <= 4'h0;
            bit_tick <= 1'h0;
        end else begin
            div_r <= (div_r == TICK_DIV - 1) ? 4'h0 : div_r + 4'h1;
            bit_tick <= (div_r == TICK_DIV - 1);
        end
        port_connected_clr <= aresetn ? clr_req : 3'h0;
    end
endmodule // uhrh_port_model
`default_nettype wire

// ==== testbench/usb_host_root_hub_config_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "uhrh_map.vh"
module usb_host_root_hub_config_regs_tb;
    logic        aclk = 1'h0, aresetn = 1'h0, tick_en = 1'h0, root_hub_reset = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [2:0]  clr_req = 3'h0, port_connected_clr, port_connected;
    logic [2:0]  nonremovable_mask, per_port_power_mask;
    logic [13:0] frame_interval_value = 14'h0, frame_left_count, low_speed_limit;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        bit_tick, frame_start, low_speed_ok, power_switch_mode, no_power_switch;
    logic        overcurrent_mode, no_overcurrent_protect;
    logic [7:0]  power_good_delay;
    int          n_fail = 0, samples_checked = 0;
    always #2.5 aclk = ~aclk;
    uhrh_cfg_regs dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_tick, .frame_interval_value,
        .root_hub_reset, .port_connected_clr, .frame_start, .frame_left_count, .low_speed_ok,
        .port_connected, .low_speed_limit, .power_switch_mode, .no_power_switch,
        .overcurrent_mode, .no_overcurrent_protect, .power_good_delay, .nonremovable_mask,
        .per_port_power_mask);
    uhrh_port_model #(.TICK_DIV(4)) u_port (.aclk, .aresetn, .tick_en, .clr_req, .bit_tick,
        .port_connected_clr);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic w(input logic [31:0] a, d, input logic [3:0] s);
        logic [1:0] r;
        wr(a, d, s, r);
        chk("bresp", {30'h0, `UHRH_RESP_OKAY}, {30'h0, r});
    endtask
    task automatic rc(input string nm, input logic [31:0] a, e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, e, d);
    endtask
    task automatic t_reset_vals;
        rc("ls_thresh", `UHRH_LS_THRESH_ADDR, 32'h00000000);
        rc("desc_a", `UHRH_DESC_A_ADDR, 32'h00001203);
        rc("desc_b", `UHRH_DESC_B_ADDR, 32'h00000000);
        chk("cfg_out", 32'h5, {28'h0, power_switch_mode, no_power_switch, overcurrent_mode,
            no_overcurrent_protect});
        chk("mask_out", 32'h0, {26'h0, nonremovable_mask, per_port_power_mask});
        $display("t_reset_vals done");
    endtask
    task automatic t_rw_bits;
        w(`UHRH_LS_THRESH_ADDR, 32'hFFFFFFFF, 4'hF);
        rc("ls_thresh", `UHRH_LS_THRESH_ADDR, 32'h00003FFF);
        w(`UHRH_DESC_A_ADDR, 32'hFFFFFFFF, 4'hF);
        rc("desc_a", `UHRH_DESC_A_ADDR, 32'hFF001B03);
        chk("pgd_out", 32'h000000FF, {24'h0, power_good_delay});
        chk("cfg_out", 32'hF, {28'h0, power_switch_mode, no_power_switch, overcurrent_mode,
            no_overcurrent_protect});
        w(`UHRH_DESC_B_ADDR, 32'hFFFFFFFF, 4'hF);
        rc("desc_b", `UHRH_DESC_B_ADDR, 32'h000E000E);
        chk("mask_out", 32'h3F, {26'h0, nonremovable_mask, per_port_power_mask});
        w(`UHRH_DESC_A_ADDR, 32'h00000000, 4'h8);
        rc("desc_a_lane", `UHRH_DESC_A_ADDR, 32'h00001B03);
        w(`UHRH_DESC_A_ADDR, 32'h00000000, 4'hF);
        rc("desc_a_clr", `UHRH_DESC_A_ADDR, 32'h00000003);
        chk("cfg_out", 32'h0, {28'h0, power_switch_mode, no_power_switch, overcurrent_mode,
            no_overcurrent_protect});
        $display("t_rw_bits done");
    endtask
    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0]  r;
        wr(32'h4004C040, 32'hFFFFFFFF, 4'hF, r);
        chk("wr_resp", {30'h0, `UHRH_RESP_SLVERR}, {30'h0, r});
        rd(32'h4004C040, d, r);
        chk("rd_resp", {30'h0, `UHRH_RESP_SLVERR}, {30'h0, r});
        chk("rd_data", 32'h0, d);
        $display("t_unmapped done");
    endtask
    task automatic t_frame;
        logic [13:0] cnt_exp;
        w(`UHRH_LS_THRESH_ADDR, 32'h00000002, 4'hF);
        chk("lsl_out", 32'h2, {18'h0, low_speed_limit});
        frame_interval_value <= 14'h0005;
        tick_en <= 1'h1;
        do @(posedge aclk); while (!frame_start);
        cnt_exp = 14'h0005;
        chk("reload", 32'h5, {18'h0, frame_left_count});
        repeat (12) begin
            do @(posedge aclk); while (!bit_tick);
            cnt_exp = (cnt_exp == 14'h0000) ? 14'h0005 : cnt_exp - 14'h0001;
            @(posedge aclk);
            chk("count", {18'h0, cnt_exp}, {18'h0, frame_left_count});
            chk("start", {31'h0, cnt_exp == 14'h0005}, {31'h0, frame_start});
            @(posedge aclk);
            chk("ls_ok", {31'h0, cnt_exp > 14'h0002}, {31'h0, low_speed_ok});
        end
        tick_en <= 1'h0;
        @(posedge aclk);
        rc("frame_stat", `UHRH_FRAME_STAT_ADDR, {cnt_exp > 14'h0002, 17'h0, cnt_exp});
        $display("t_frame done");
    endtask
    task automatic t_ports;
        w(`UHRH_DESC_B_ADDR, 32'h0000000A, 4'hF);
        root_hub_reset <= 1'h1;
        @(posedge aclk);
        root_hub_reset <= 1'h0;
        repeat (2) @(posedge aclk);
        chk("conn_set", 32'h5, {29'h0, port_connected});
        clr_req <= 3'h1;
        @(posedge aclk);
        clr_req <= 3'h0;
        repeat (3) @(posedge aclk);
        chk("conn_clr", 32'h4, {29'h0, port_connected});
        clr_req <= 3'h1;
        @(posedge aclk);
        clr_req <= 3'h0;
        root_hub_reset <= 1'h1;
        @(posedge aclk);
        root_hub_reset <= 1'h0;
        repeat (2) @(posedge aclk);
        chk("conn_set_wins", 32'h5, {29'h0, port_connected});
        $display("t_ports done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100us;
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset_vals();
        t_rw_bits();
        t_unmapped();
        t_frame();
        t_ports();
        end_sim();
    end
endmodule // usb_host_root_hub_config_regs_tb
`default_nettype wire
